/* File: hdl/twi_pkg.sv */
package twi_pkg;

    // ****************************************
    // Address, timing and layout constants
    // ****************************************
    localparam logic [5:0] ADDR_UPPER = 6'h10;
    localparam logic [3:0] BIT_COUNT = 4'h8;
    localparam int unsigned CLOCK_MHZ = 200;
    localparam int unsigned STORE_TIME_MS = 50;
    localparam int unsigned STORE_CYCLES_DFLT = STORE_TIME_MS * 1000 * CLOCK_MHZ;
    localparam logic [7:0] STORE_REG_INDEX = 8'hff;
    localparam int unsigned STORE_BIT_POS = 0;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned SCL_IDX = 0;
    localparam int unsigned SDA_IDX = 1;
    localparam int unsigned STRAP_IDX = 2;
    localparam logic [2:0] LINE_RESET = 3'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } wr_word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } twi_state_t;

endpackage

/* File: hdl/twi_fifo.sv */
`timescale 1ns/1ps
module twi_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    wire logic full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    wire logic empty = (wr_ptr_ff == rd_ptr_ff);
    wire logic push = i_in_valid && !full;
    wire logic pop = i_out_ready && !empty;

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end

endmodule

/* File: hdl/two_wire_slave_front_end.sv */
// Notes on behaviour
// - Slave only; never makes clock, start, stop
// - Works at 100 and 400 kbps
// - Same framing at both speeds
// - Answers address 010000 plus strap bit
// - Strap low gives 0, high gives 1
// - Eighth address bit: 0 write, 1 read
// - Data line only pulled low or released
// - Lines released while bus idle
// - Acknowledge address only on match
// - Receiver acknowledges in ninth clock
// - Unmapped register reads return 00h
// - Store bit: ignore bus 50 ms, clear
`timescale 1ns/1ps
module two_wire_slave_front_end
#(
    parameter int unsigned STORE_CYCLES = twi_pkg::STORE_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Bus pins; clock line is input only
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Strap
    input wire logic i_address_strap_pin,
    // Written register stream
    output logic o_wr_valid,
    output twi_pkg::wr_word_t o_wr_word,
    input wire logic i_wr_ready,
    // Read-back port
    output logic [7:0] o_rd_index,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_hit,
    // Store to nonvolatile
    output logic o_store_busy,
    output logic o_store_done
);
    import twi_pkg::*;

    // ****************************************
    // Line synchronisers
    // ****************************************
    wire logic [2:0] pins = {i_address_strap_pin, i_sda, i_scl};
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] line_ff;
    logic [2:0] prev_ff;

    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge i_clock) begin
            if (!i_reset_n) begin
                s1_ff[g] <= LINE_RESET[g];
                s2_ff[g] <= LINE_RESET[g];
                s3_ff[g] <= LINE_RESET[g];
                line_ff[g] <= LINE_RESET[g];
                prev_ff[g] <= LINE_RESET[g];
            end else begin
                s1_ff[g] <= pins[g];
                s2_ff[g] <= s1_ff[g];
                s3_ff[g] <= s2_ff[g];
                if (s2_ff[g] == s3_ff[g]) begin
                    line_ff[g] <= s3_ff[g];
                end
                prev_ff[g] <= line_ff[g];
            end
        end
    end

    // ****************************************
    // Bus event decode
    // ****************************************
    wire logic scl = line_ff[SCL_IDX];
    wire logic sda = line_ff[SDA_IDX];
    wire logic scl_rise = scl && !prev_ff[SCL_IDX];
    wire logic scl_fall = !scl && prev_ff[SCL_IDX];
    // Edges found by oversampling, same at any bus rate
    wire logic start_seen = scl && prev_ff[SCL_IDX] && !sda && prev_ff[SDA_IDX];
    wire logic stop_seen = scl && prev_ff[SCL_IDX] && sda && !prev_ff[SDA_IDX];

    twi_state_t state_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic [7:0] ptr_ff;
    logic rw_ff;
    logic first_ff;
    logic nack_ff;
    logic oe_ff;
    logic store_pend_ff;
    logic store_busy_ff;
    logic store_done_ff;
    logic [23:0] store_cnt_ff;
    logic fifo_ready;

    wire logic byte_end = scl_fall && (cnt_ff == BIT_COUNT);
    wire logic addr_match = (shift_ff[7:2] == ADDR_UPPER)
        && (shift_ff[1] == line_ff[STRAP_IDX]);
    wire logic wr_push = byte_end && (state_ff == ST_WR_BYTE) && !first_ff;
    wire logic wr_accept = first_ff || fifo_ready;
    wire logic store_hit = wr_push && fifo_ready && (ptr_ff == STORE_REG_INDEX)
        && shift_ff[STORE_BIT_POS];
    wire logic [7:0] rd_byte = i_rd_hit ? i_rd_data : RD_UNMAPPED;
    wire logic shifting = (state_ff == ST_ADDR) || (state_ff == ST_WR_BYTE)
        || (state_ff == ST_RD_BYTE);

    // ****************************************
    // Protocol state machine
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            nack_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (store_busy_ff) begin
            state_ff <= ST_IDLE;
            oe_ff <= 1'b0;
        end else if (stop_seen) begin
            state_ff <= ST_IDLE;
            oe_ff <= 1'b0;
        end else if (start_seen) begin
            state_ff <= ST_ADDR;
            cnt_ff <= 4'h0;
            oe_ff <= 1'b0;
        end else if (scl_rise) begin
            if (shifting) begin
                shift_ff <= {shift_ff[6:0], sda};
                cnt_ff <= cnt_ff + 4'h1;
            end
            if (state_ff == ST_RD_ACK) begin
                nack_ff <= sda;
            end
        end else if (scl_fall) begin
            unique case (state_ff)
                ST_IDLE: begin
                    oe_ff <= 1'b0;
                end
                ST_ADDR: begin
                    if (cnt_ff == BIT_COUNT) begin
                        rw_ff <= shift_ff[0];
                        first_ff <= 1'b1;
                        oe_ff <= addr_match;
                        state_ff <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_ff <= 4'h0;
                    if (rw_ff) begin
                        tx_ff <= rd_byte;
                        oe_ff <= !rd_byte[7];
                        state_ff <= ST_RD_BYTE;
                    end else begin
                        oe_ff <= 1'b0;
                        state_ff <= ST_WR_BYTE;
                    end
                end
                ST_WR_BYTE: begin
                    if (cnt_ff == BIT_COUNT) begin
                        oe_ff <= wr_accept;
                        state_ff <= ST_WR_ACK;
                        if (first_ff) begin
                            ptr_ff <= shift_ff;
                        end else if (fifo_ready) begin
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                    end
                end
                ST_WR_ACK: begin
                    oe_ff <= 1'b0;
                    first_ff <= 1'b0;
                    cnt_ff <= 4'h0;
                    state_ff <= ST_WR_BYTE;
                end
                ST_RD_BYTE: begin
                    if (cnt_ff == BIT_COUNT) begin
                        oe_ff <= 1'b0;
                        ptr_ff <= ptr_ff + 8'h01;
                        state_ff <= ST_RD_ACK;
                    end else begin
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        oe_ff <= !tx_ff[6];
                    end
                end
                ST_RD_ACK: begin
                    cnt_ff <= 4'h0;
                    if (nack_ff) begin
                        oe_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else begin
                        tx_ff <= rd_byte;
                        oe_ff <= !rd_byte[7];
                        state_ff <= ST_RD_BYTE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Store to nonvolatile dead time
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            store_pend_ff <= 1'b0;
            store_busy_ff <= 1'b0;
            store_done_ff <= 1'b0;
            store_cnt_ff <= 24'h000000;
        end else begin
            store_done_ff <= 1'b0;
            if (store_hit) begin
                store_pend_ff <= 1'b1;
            end else if (stop_seen && store_pend_ff) begin
                store_pend_ff <= 1'b0;
                store_busy_ff <= 1'b1;
                store_cnt_ff <= 24'(STORE_CYCLES - 1);
            end else if (store_busy_ff) begin
                if (store_cnt_ff == 24'h000000) begin
                    store_busy_ff <= 1'b0;
                    store_done_ff <= 1'b1;
                end else begin
                    store_cnt_ff <= store_cnt_ff - 24'h000001;
                end
            end
        end
    end

    // ****************************************
    // Write stream buffer
    // ****************************************
    wr_word_t push_word;
    assign push_word = '{index: ptr_ff, data: shift_ff};

    twi_fifo #(
        .WIDTH($bits(wr_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_in_valid(wr_push),
        .o_in_ready(fifo_ready),
        .i_in_data(push_word),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data(o_wr_word)
    );

    // Open drain: level is always low, only enable moves
    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_ff;
    assign o_rd_index = ptr_ff;
    assign o_store_busy = store_busy_ff;
    assign o_store_done = store_done_ff;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    sequence addr_done_s;
        scl_fall && (state_ff == ST_ADDR) && (cnt_ff == BIT_COUNT) && !store_busy_ff
            && !stop_seen && !start_seen;
    endsequence

    sequence wr_done_s;
        scl_fall && (state_ff == ST_WR_BYTE) && (cnt_ff == BIT_COUNT) && !store_busy_ff
            && !stop_seen && !start_seen;
    endsequence

    idle_release_a: assert property (state_ff == ST_IDLE |=> !o_sda_oe)
        else $error("data line held while idle");
    drain_only_a: assert property (o_sda_oe |-> !o_sda_out)
        else $error("data line driven high");
    addr_ack_a: assert property (addr_done_s ##0 addr_match
        |=> o_sda_oe && state_ff == ST_ADDR_ACK)
        else $error("matching address not acknowledged");
    addr_nack_a: assert property (addr_done_s ##0 !addr_match
        |=> !o_sda_oe && state_ff == ST_IDLE)
        else $error("foreign address acknowledged");
    strap_bit_a: assert property (addr_done_s
        ##0 (shift_ff[7:1] == {ADDR_UPPER, line_ff[STRAP_IDX]}) |=> o_sda_oe)
        else $error("strap bit mismatch on acknowledge");
    dir_read_a: assert property (scl_fall && state_ff == ST_ADDR_ACK && rw_ff
        && !store_busy_ff && !stop_seen && !start_seen |=> state_ff == ST_RD_BYTE)
        else $error("read direction not taken");
    wr_ack_a: assert property (wr_done_s ##0 wr_accept |=> o_sda_oe ##1 o_sda_oe [*1])
        else $error("written byte not acknowledged");
    unmapped_a: assert property (scl_fall && state_ff == ST_ADDR_ACK && rw_ff
        && !i_rd_hit && !store_busy_ff && !stop_seen && !start_seen |=> tx_ff == RD_UNMAPPED)
        else $error("unmapped read not zero");
    store_quiet_a: assert property (store_busy_ff |=> state_ff == ST_IDLE ##1 !o_sda_oe)
        else $error("bus served during store");
    sync_stable_a: assert property ($changed(line_ff) |-> $past(s2_ff) == $past(s3_ff))
        else $error("line changed without agreement");

endmodule

/* File: verif/twi_master_model.sv */
`timescale 1ns/1ps
module twi_master_model (
    // Clock for pacing
    input wire logic i_clock,
    // Resolved bus lines and pulls
    input wire logic i_sda,
    output logic o_scl_low,
    output logic o_sda_low
);
    int lo_cyc = 12;
    int hi_cyc = 13;

    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    // ****************************************
    // Framing, always made by this side
    // ****************************************
    task automatic start_cond();
        wait_cyc(lo_cyc / 2);
        o_sda_low = 1'b0;
        wait_cyc(lo_cyc / 2);
        o_scl_low = 1'b0;
        wait_cyc(hi_cyc);
        o_sda_low = 1'b1;
        wait_cyc(hi_cyc);
        o_scl_low = 1'b1;
    endtask

    task automatic stop_cond();
        wait_cyc(lo_cyc / 2);
        o_sda_low = 1'b1;
        wait_cyc(lo_cyc / 2);
        o_scl_low = 1'b0;
        wait_cyc(hi_cyc);
        o_sda_low = 1'b0;
        wait_cyc(hi_cyc);
    endtask

    // Data set mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        wait_cyc(lo_cyc / 2);
        o_sda_low = !b;
        wait_cyc(lo_cyc - lo_cyc / 2);
        o_scl_low = 1'b0;
        wait_cyc(hi_cyc / 2);
        s = i_sda;
        wait_cyc(hi_cyc - hi_cyc / 2);
        o_scl_low = 1'b1;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                        output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_tx, ack_rx);
    endtask
endmodule

/* File: verif/two_wire_slave_front_end_tb_top.sv */
`timescale 1ns/1ps
module two_wire_slave_front_end_tb_top;
    import twi_pkg::*;
    localparam int unsigned STORE_N = 2000;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic strap = 1'b0;
    logic wr_ready = 1'b0;
    logic scl_low, sda_low, sda_out, sda_oe, wr_valid, store_busy, store_done;
    logic scl, sda, rd_hit;
    logic [7:0] rd_index, rd_data;
    wr_word_t wr_word;
    int err_total = 0;
    int checked = 0;
    int busy_cnt = 0;
    int done_cnt = 0;

    always #2.5 i_clock = ~i_clock;
    assign scl = !scl_low;
    assign sda = !sda_low && !(sda_oe && !sda_out);
    assign rd_hit = rd_index < 8'h0a;
    assign rd_data = rd_index ^ 8'h5a;
    always @(posedge i_clock) begin
        busy_cnt <= busy_cnt + int'(store_busy === 1'b1);
        done_cnt <= done_cnt + int'(store_done === 1'b1);
    end

    twi_master_model i_master (.i_clock(i_clock), .i_sda(sda), .o_scl_low(scl_low),
        .o_sda_low(sda_low));
    two_wire_slave_front_end #(.STORE_CYCLES(STORE_N)) i_dut (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .i_address_strap_pin(strap), .o_wr_valid(wr_valid),
        .o_wr_word(wr_word), .i_wr_ready(wr_ready), .o_rd_index(rd_index),
        .i_rd_data(rd_data), .i_rd_hit(rd_hit), .o_store_busy(store_busy),
        .o_store_done(store_done));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic [7:0] rx;
        logic nack;
        i_master.xfer(b, 1'b1, rx, nack);
        ack = !nack;
    endtask

    task automatic open_wr(output logic ack);
        i_master.start_cond();
        send({ADDR_UPPER, strap, 1'b0}, ack);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_idle();
        check("oe", 0, sda_oe);
        check("sda_out", 0, sda_out);
        check("idle", 0, {wr_valid, store_busy, store_done, rd_index});
    endtask

    task automatic sc_address();
        logic ack;
        for (int s = 0; s < 2; s++) begin
            strap = s[0];
            repeat (10) @(negedge i_clock);
            for (int a = 0; a < 2; a++) begin
                i_master.start_cond();
                send({ADDR_UPPER, a[0], 1'b0}, ack);
                i_master.stop_cond();
                check("addr_ack", a[0] == s[0], ack);
            end
        end
        i_master.start_cond();
        send({6'h11, strap, 1'b0}, ack);
        i_master.stop_cond();
        check("upper_ack", 0, ack);
        check("oe_stop", 0, sda_oe);
    endtask

    task automatic sc_speed();
        logic a0, a1;
        for (int k = 0; k < 2; k++) begin
            i_master.lo_cyc = k ? 1000 : 250;
            i_master.hi_cyc = k ? 1000 : 250;
            open_wr(a0);
            send(8'h02, a1);
            i_master.stop_cond();
            check("speed_ack", 2'b11, {a0, a1});
        end
        i_master.lo_cyc = 12;
        i_master.hi_cyc = 13;
    endtask

    task automatic sc_write_fifo();
        logic ack;
        open_wr(ack);
        send(8'h05, ack);
        for (int i = 0; i < 5; i++) begin
            send(8'h30 + 8'(i), ack);
            check("wr_ack", i < 4, ack);
        end
        i_master.stop_cond();
        for (int i = 0; i < 4; i++) begin
            check("wr_word", {1'b1, 8'h05 + 8'(i), 8'h30 + 8'(i)}, {wr_valid, wr_word});
            wr_ready = 1'b1;
            @(negedge i_clock);
        end
        check("drained", 0, wr_valid);
    endtask

    task automatic sc_read();
        logic a0, a1, a2, nack;
        logic [7:0] rx0, rx1;
        open_wr(a0);
        send(8'h09, a1);
        i_master.start_cond();
        send({ADDR_UPPER, strap, 1'b1}, a2);
        check("rd_acks", 3'b111, {a0, a1, a2});
        i_master.xfer(8'hff, 1'b0, rx0, nack);
        i_master.xfer(8'hff, 1'b1, rx1, nack);
        i_master.stop_cond();
        check("rd_mapped", 8'h53, rx0);
        check("rd_unmapped", RD_UNMAPPED, rx1);
        check("rd_ptr", 8'h0b, rd_index);
        check("rd_oe", 0, sda_oe);
    endtask

    task automatic sc_store();
        logic ack;
        int b0;
        int d0;
        int n;
        b0 = busy_cnt;
        d0 = done_cnt;
        open_wr(ack);
        send(STORE_REG_INDEX, ack);
        send(8'h01, ack);
        i_master.stop_cond();
        check("store_ack", 1, ack);
        open_wr(ack);
        i_master.stop_cond();
        check("busy_ack", 0, ack);
        check("busy", 1, store_busy);
        n = 0;
        while (store_busy !== 1'b0 && n < 3000) begin
            @(negedge i_clock);
            n++;
        end
        if (n == 3000) begin
            check("store_wait", 0, 1);
            tally_and_finish();
        end
        repeat (2) @(negedge i_clock);
        check("busy_len", STORE_N, busy_cnt - b0);
        check("done_cnt", 1, done_cnt - d0);
        open_wr(ack);
        i_master.stop_cond();
        check("after_ack", 1, ack);
    endtask

    initial begin
        repeat (2) @(negedge i_clock);
        i_reset_n = 1'b1;
        repeat (20) @(negedge i_clock);
        sc_idle();
        sc_address();
        sc_speed();
        sc_write_fifo();
        sc_read();
        sc_store();
        tally_and_finish();
    end
endmodule
